// ### inc/ppw_params.svh
// Constants for the pin port with PWM, square wave and wake-up
`ifndef PPW_PARAMS_SVH
`define PPW_PARAMS_SVH

`define PPW_NPIN          19
`define PPW_NSQW          16

// Register byte offsets
`define PPW_OFF_DIR       12'h000
`define PPW_OFF_OUT       12'h004
`define PPW_OFF_IN        12'h008
`define PPW_OFF_DRIVE     12'h00c
`define PPW_OFF_PULLUP    12'h010
`define PPW_OFF_PULLDN    12'h014
`define PPW_OFF_INDIS     12'h018
`define PPW_OFF_WAKE_EN   12'h01c
`define PPW_OFF_WAKE_POL  12'h020
`define PPW_OFF_WAKE_CHG  12'h024
`define PPW_OFF_FN_PWM    12'h028
`define PPW_OFF_FN_SQW    12'h02c
`define PPW_OFF_PWM_PER   12'h030
`define PPW_OFF_SQW_PER   12'h034
`define PPW_OFF_PWR_CTRL  12'h038
`define PPW_OFF_PWR_STAT  12'h03c
`define PPW_OFF_INT_STAT  12'h040
`define PPW_OFF_INT_MASK  12'h044
`define PPW_OFF_PWM_DUTY  12'h100
`define PPW_OFF_SQW_DUTY  12'h180

// Field positions
`define PPW_PWR_IDLE_BIT  0
`define PPW_PWR_DEEP_BIT  1
`define PPW_INT_RX_BIT    19

// Reset values
`define PPW_RST_PINS      19'h00000
`define PPW_RST_CNT       16'h0000

// Timing
`define PPW_CLK_HZ        100000000
`define PPW_PWM_TICK_HZ   1000000
`define PPW_PWM_DIV       (`PPW_CLK_HZ / `PPW_PWM_TICK_HZ)
`define PPW_SQW_MAX_HZ    4000000
`define PPW_SQW_MIN_PER   ((`PPW_CLK_HZ + `PPW_SQW_MAX_HZ - 1) / `PPW_SQW_MAX_HZ)
`define PPW_RST_HOLD_MS   100
`define PPW_RST_HOLD_CYC  ((`PPW_CLK_HZ / 1000) * `PPW_RST_HOLD_MS)

`endif

// ### inc/ppw_pkg.sv
// Types for the pin port with PWM, square wave and wake-up
package ppw_pkg;
	typedef logic [18:0] ppw_pins_t;
	typedef logic [15:0] ppw_cnt_t;
	typedef enum logic [1:0] {PPW_RUN, PPW_STANDBY, PPW_DEEP} ppw_pwr_t;
endpackage

// ### hw/ppw_cmp_ch.sv
// One compare channel: output high while the count is below the high time
`timescale 1ns/1ps
module ppw_cmp_ch (
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic           en,
	input  wire ppw_pkg::ppw_cnt_t cnt,
	input  wire ppw_pkg::ppw_cnt_t high_time,
	output logic                wave
);
	import ppw_pkg::*;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wave <= 1'b0;
		end else begin
			wave <= en & (cnt < high_time);
		end
	end
endmodule // ppw_cmp_ch

// ### hw/ppw_wake.sv
// One wake detector: level high, level low or any change
`timescale 1ns/1ps
module ppw_wake (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic pin,
	input  wire logic en,
	input  wire logic pol,
	input  wire logic chg,
	output logic      hit
);
	import ppw_pkg::*;

	logic prev_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= pin;
		end
	end

	// R4 level trigger
	// R5 change trigger
	assign hit = en & (chg ? (pin ^ prev_reg) : (pin == pol));
endmodule // ppw_wake

// ### hw/ppw_top.sv
// Pin port with PWM, square wave output, wake-up and power states
// Behaviour
// R1 - Nineteen pins, each with its own input or output direction.
// R2 - Per-pin drive select, standard or high, applied while the pin outputs.
// R3 - Per-pin pull-up, pull-down or none, and input buffer disconnect.
// R4 - Every pin can wake on a high or low level, chosen per pin.
// R5 - A wake pin can instead wake on any change of its input.
// R6 - Any pin can output PWM with frequency up to 1 MHz.
// R7 - PWM duty spans fully low through fully high inclusive.
// R8 - PWM duty resolution equals the period in microseconds.
// R9 - Square wave on 16 pins, common frequency, independent duty per pin.
// R10 - Square wave from 0 Hz to 4 MHz, 50% high time by default.
// R11 - Standby entered when idle-until-event is requested and nothing is pending.
// R12 - Any interrupt, including a serial character, ends standby without reset.
// R13 - Waking from deep sleep requests a full system reset.
// R14 - External reset input must be held low at least 100 ms.
// R15 - PWM counts a 1 MHz tick, period and duty in microseconds.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ppw_params.svh"
module ppw_top #(
	parameter int unsigned RST_HOLD_CYC = `PPW_RST_HOLD_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire ppw_pkg::ppw_pins_t configurable_pin_in,
	output ppw_pkg::ppw_pins_t     configurable_pin_out,
	output ppw_pkg::ppw_pins_t     configurable_pin_oe,
	output ppw_pkg::ppw_pins_t     pin_drive_high,
	output ppw_pkg::ppw_pins_t     pin_pull_up,
	output ppw_pkg::ppw_pins_t     pin_pull_down,
	output ppw_pkg::ppw_pins_t     pin_input_en,
	input  wire logic              uart_rx_char,
	input  wire logic              hw_reset_in_low,
	output logic                   standby,
	output logic                   deep_sleep,
	output logic                   sys_reset_req,
	output logic                   irq
);
	import ppw_pkg::*;

	localparam int NP = `PPW_NPIN;
	localparam int NS = `PPW_NSQW;

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	ppw_pins_t dir_reg, out_reg, drive_reg, pullup_reg, pulldn_reg, indis_reg;
	ppw_pins_t wake_en_reg, wake_pol_reg, wake_chg_reg, fn_pwm_reg;
	logic [NS-1:0] fn_sqw_reg;
	ppw_cnt_t  pwm_per_reg, sqw_per_reg;
	ppw_cnt_t  pwm_duty_reg [NP];
	ppw_cnt_t  sqw_duty_reg [NS];
	logic [19:0] int_stat_reg, int_mask_reg;
	ppw_pwr_t  pwr_reg;
	logic [31:0] rdata;
	logic        rd_ok;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	wire       setup    = psel & ~penable;
	wire       wr_acc   = psel & penable & pready & pwrite;
	wire [9:0] widx     = paddr[11:2];
	wire       wr_dir   = wr_acc & (paddr == `PPW_OFF_DIR);
	wire       wr_out   = wr_acc & (paddr == `PPW_OFF_OUT);
	wire       wr_drv   = wr_acc & (paddr == `PPW_OFF_DRIVE);
	wire       wr_pu    = wr_acc & (paddr == `PPW_OFF_PULLUP);
	wire       wr_pd    = wr_acc & (paddr == `PPW_OFF_PULLDN);
	wire       wr_indis = wr_acc & (paddr == `PPW_OFF_INDIS);
	wire       wr_wen   = wr_acc & (paddr == `PPW_OFF_WAKE_EN);
	wire       wr_wpol  = wr_acc & (paddr == `PPW_OFF_WAKE_POL);
	wire       wr_wchg  = wr_acc & (paddr == `PPW_OFF_WAKE_CHG);
	wire       wr_fpwm  = wr_acc & (paddr == `PPW_OFF_FN_PWM);
	wire       wr_fsqw  = wr_acc & (paddr == `PPW_OFF_FN_SQW);
	wire       wr_pper  = wr_acc & (paddr == `PPW_OFF_PWM_PER);
	wire       wr_sper  = wr_acc & (paddr == `PPW_OFF_SQW_PER);
	wire       wr_pwr   = wr_acc & (paddr == `PPW_OFF_PWR_CTRL);
	wire       wr_istat = wr_acc & (paddr == `PPW_OFF_INT_STAT);
	wire       wr_imask = wr_acc & (paddr == `PPW_OFF_INT_MASK);
	wire [9:0] pd_base  = 10'(`PPW_OFF_PWM_DUTY >> 2);
	wire [9:0] sd_base  = 10'(`PPW_OFF_SQW_DUTY >> 2);
	wire [9:0] pd_idx   = widx - pd_base;
	wire [9:0] sd_idx   = widx - sd_base;
	wire       in_pd    = (widx >= pd_base) & (pd_idx < 10'(NP));
	wire       in_sd    = (widx >= sd_base) & (sd_idx < 10'(NS));

	// Input buffer disconnect forces the sampled level low
	ppw_pins_t pin_val;
	// R3 input disconnect
	assign pin_val = configurable_pin_in & ~indis_reg;

	always_comb begin
		rd_ok = 1'b1;
		rdata = 32'h00000000;
		case (paddr)
			`PPW_OFF_DIR:      rdata = {13'h0000, dir_reg};
			`PPW_OFF_OUT:      rdata = {13'h0000, out_reg};
			`PPW_OFF_IN:       rdata = {13'h0000, pin_val};
			`PPW_OFF_DRIVE:    rdata = {13'h0000, drive_reg};
			`PPW_OFF_PULLUP:   rdata = {13'h0000, pullup_reg};
			`PPW_OFF_PULLDN:   rdata = {13'h0000, pulldn_reg};
			`PPW_OFF_INDIS:    rdata = {13'h0000, indis_reg};
			`PPW_OFF_WAKE_EN:  rdata = {13'h0000, wake_en_reg};
			`PPW_OFF_WAKE_POL: rdata = {13'h0000, wake_pol_reg};
			`PPW_OFF_WAKE_CHG: rdata = {13'h0000, wake_chg_reg};
			`PPW_OFF_FN_PWM:   rdata = {13'h0000, fn_pwm_reg};
			`PPW_OFF_FN_SQW:   rdata = {16'h0000, fn_sqw_reg};
			`PPW_OFF_PWM_PER:  rdata = {16'h0000, pwm_per_reg};
			`PPW_OFF_SQW_PER:  rdata = {16'h0000, sqw_per_reg};
			`PPW_OFF_PWR_CTRL: rdata = 32'h00000000;
			`PPW_OFF_PWR_STAT: rdata = {30'h00000000, pwr_reg};
			`PPW_OFF_INT_STAT: rdata = {12'h000, int_stat_reg};
			`PPW_OFF_INT_MASK: rdata = {12'h000, int_mask_reg};
			default: begin
				if (in_pd) begin
					rdata = {16'h0000, pwm_duty_reg[pd_idx[4:0]]};
				end else if (in_sd) begin
					rdata = {16'h0000, sqw_duty_reg[sd_idx[3:0]]};
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// No wait state: ready in the first access cycle, data latched at setup
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~rd_ok;
			if (setup && !pwrite) begin
				prdata <= rd_ok ? rdata : 32'h00000000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin configuration

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dir_reg      <= `PPW_RST_PINS;
			out_reg      <= `PPW_RST_PINS;
			drive_reg    <= `PPW_RST_PINS;
			pullup_reg   <= `PPW_RST_PINS;
			pulldn_reg   <= `PPW_RST_PINS;
			indis_reg    <= `PPW_RST_PINS;
			wake_en_reg  <= `PPW_RST_PINS;
			wake_pol_reg <= `PPW_RST_PINS;
			wake_chg_reg <= `PPW_RST_PINS;
			fn_pwm_reg   <= `PPW_RST_PINS;
			fn_sqw_reg   <= 16'h0000;
			pwm_per_reg  <= `PPW_RST_CNT;
			sqw_per_reg  <= `PPW_RST_CNT;
			int_mask_reg <= 20'h00000;
		end else begin
			// R1 direction per pin
			if (wr_dir)   dir_reg      <= pwdata[18:0];
			if (wr_out)   out_reg      <= pwdata[18:0];
			// R2 drive select
			if (wr_drv)   drive_reg    <= pwdata[18:0];
			// R3 pull select
			if (wr_pu)    pullup_reg   <= pwdata[18:0];
			if (wr_pd)    pulldn_reg   <= pwdata[18:0];
			if (wr_indis) indis_reg    <= pwdata[18:0];
			if (wr_wen)   wake_en_reg  <= pwdata[18:0];
			if (wr_wpol)  wake_pol_reg <= pwdata[18:0];
			if (wr_wchg)  wake_chg_reg <= pwdata[18:0];
			if (wr_fpwm)  fn_pwm_reg   <= pwdata[18:0];
			if (wr_fsqw)  fn_sqw_reg   <= pwdata[15:0];
			if (wr_pper)  pwm_per_reg  <= pwdata[15:0];
			if (wr_sper)  sqw_per_reg  <= pwdata[15:0];
			if (wr_imask) int_mask_reg <= pwdata[19:0];
		end
	end

	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NP; i++) begin
			if (!rst_n) begin
				pwm_duty_reg[i] <= `PPW_RST_CNT;
			end else if (wr_acc && in_pd && pd_idx == 10'(i)) begin
				pwm_duty_reg[i] <= pwdata[15:0];
			end
		end
		for (int j = 0; j < NS; j++) begin
			if (!rst_n) begin
				sqw_duty_reg[j] <= `PPW_RST_CNT;
			end else if (wr_acc && in_sd && sd_idx == 10'(j)) begin
				sqw_duty_reg[j] <= pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// PWM timebase

	logic [6:0] tick_cnt_reg;
	logic       pwm_tick;
	ppw_cnt_t   pwm_cnt_reg;
	wire        tick_wrap = (tick_cnt_reg == 7'(`PPW_PWM_DIV - 1));
	wire        pwm_wrap  = (pwm_cnt_reg >= pwm_per_reg - 16'h0001);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tick_cnt_reg <= 7'h00;
			pwm_tick     <= 1'b0;
			pwm_cnt_reg  <= `PPW_RST_CNT;
		end else begin
			// R15 1 MHz tick
			tick_cnt_reg <= tick_wrap ? 7'h00 : tick_cnt_reg + 7'h01;
			pwm_tick     <= tick_wrap;
			// R8 one step per microsecond
			if (pwm_per_reg == 16'h0000) begin
				pwm_cnt_reg <= `PPW_RST_CNT;
			end else if (pwm_tick) begin
				pwm_cnt_reg <= pwm_wrap ? `PPW_RST_CNT : pwm_cnt_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Square wave timebase

	ppw_cnt_t sqw_cnt_reg;
	ppw_cnt_t sqw_per;
	wire      sqw_on = (sqw_per_reg != 16'h0000);
	// R10 clamp to 4 MHz, zero stops
	assign sqw_per = (sqw_per_reg < 16'(`PPW_SQW_MIN_PER)) ? 16'(`PPW_SQW_MIN_PER) : sqw_per_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sqw_cnt_reg <= `PPW_RST_CNT;
		end else if (!sqw_on || sqw_cnt_reg >= sqw_per - 16'h0001) begin
			sqw_cnt_reg <= `PPW_RST_CNT;
		end else begin
			sqw_cnt_reg <= sqw_cnt_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channels and wake detectors

	ppw_pins_t     pwm_wave, wake_hit;
	logic [NS-1:0] sqw_wave;

	for (genvar g = 0; g < NP; g++) begin : g_pin
		// R6 any pin PWM
		// R7 zero and full duty
		ppw_cmp_ch u_pwm (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.en        (pwm_per_reg != 16'h0000),
			.cnt       (pwm_cnt_reg),
			.high_time (pwm_duty_reg[g]),
			.wave      (pwm_wave[g])
		);
		ppw_wake u_wake (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.pin      (pin_val[g]),
			.en       (wake_en_reg[g]),
			.pol      (wake_pol_reg[g]),
			.chg      (wake_chg_reg[g]),
			.hit      (wake_hit[g])
		);
	end

	for (genvar s = 0; s < NS; s++) begin : g_sqw
		// R9 shared period, own duty
		ppw_cmp_ch u_sqw (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.en        (sqw_on),
			.cnt       (sqw_cnt_reg),
			.high_time ((sqw_duty_reg[s] == 16'h0000) ? (sqw_per >> 1) : sqw_duty_reg[s]),
			.wave      (sqw_wave[s])
		);
	end

	// Output source select: PWM over square wave over plain data
	ppw_pins_t pin_drive_val;
	assign pin_drive_val = (fn_pwm_reg & pwm_wave)
	                     | (~fn_pwm_reg & {3'b000, fn_sqw_reg} & {3'b000, sqw_wave})
	                     | (~fn_pwm_reg & ~{3'b000, fn_sqw_reg} & out_reg);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			configurable_pin_out <= `PPW_RST_PINS;
			configurable_pin_oe  <= `PPW_RST_PINS;
			pin_drive_high       <= `PPW_RST_PINS;
			pin_pull_up          <= `PPW_RST_PINS;
			pin_pull_down        <= `PPW_RST_PINS;
			pin_input_en         <= `PPW_RST_PINS;
		end else begin
			configurable_pin_out <= pin_drive_val;
			// R1 enable per direction
			configurable_pin_oe  <= dir_reg | fn_pwm_reg | {3'b000, fn_sqw_reg};
			// R2 high drive only while output
			pin_drive_high       <= drive_reg & (dir_reg | fn_pwm_reg | {3'b000, fn_sqw_reg});
			// R3 pulls exclusive, both set means none
			pin_pull_up          <= pullup_reg & ~pulldn_reg;
			pin_pull_down        <= pulldn_reg & ~pullup_reg;
			pin_input_en         <= ~indis_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status

	wire [19:0] int_set = {uart_rx_char, wake_hit};
	wire [19:0] int_clr = wr_istat ? pwdata[19:0] : 20'h00000;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			int_stat_reg <= 20'h00000;
			irq          <= 1'b0;
		end else begin
			int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
			irq          <= |(((int_stat_reg & ~int_clr) | int_set) & int_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power states and reset request

	wire pending = |(int_stat_reg & int_mask_reg) | uart_rx_char;
	logic [31:0] rst_hold_cnt_reg;
	wire         rst_hold_done = (rst_hold_cnt_reg == RST_HOLD_CYC - 1);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwr_reg          <= PPW_RUN;
			sys_reset_req    <= 1'b0;
			rst_hold_cnt_reg <= 32'h00000000;
			standby          <= 1'b0;
			deep_sleep       <= 1'b0;
		end else begin
			sys_reset_req <= 1'b0;
			standby       <= (pwr_reg == PPW_STANDBY);
			deep_sleep    <= (pwr_reg == PPW_DEEP);
			// R14 hold filter on reset pin
			if (hw_reset_in_low) begin
				rst_hold_cnt_reg <= 32'h00000000;
			end else if (!rst_hold_done) begin
				rst_hold_cnt_reg <= rst_hold_cnt_reg + 32'h00000001;
			end
			if (!hw_reset_in_low && rst_hold_cnt_reg == RST_HOLD_CYC - 2) begin
				sys_reset_req <= 1'b1;
			end
			case (pwr_reg)
				PPW_RUN: begin
					if (wr_pwr && pwdata[`PPW_PWR_DEEP_BIT]) begin
						pwr_reg <= PPW_DEEP;
					// R11 idle until event
					end else if (wr_pwr && pwdata[`PPW_PWR_IDLE_BIT] && !pending) begin
						pwr_reg <= PPW_STANDBY;
					end
				end
				PPW_STANDBY: begin
					// R12 resume without reset
					if (pending) begin
						pwr_reg <= PPW_RUN;
					end
				end
				PPW_DEEP: begin
					// R13 wake through reset
					if (|wake_hit) begin
						pwr_reg       <= PPW_RUN;
						sys_reset_req <= 1'b1;
					end
				end
				default: pwr_reg <= PPW_RUN;
			endcase
		end
	end

endmodule // ppw_top

// ### verification/ppw_pin_load.sv
// Pin load model: loopback of driven pins, pull resistors and an outside source
`timescale 1ns/1ps
module ppw_pin_load (
	input  wire ppw_pkg::ppw_pins_t pin_out,
	input  wire ppw_pkg::ppw_pins_t pin_oe,
	input  wire ppw_pkg::ppw_pins_t pull_up,
	input  wire ppw_pkg::ppw_pins_t pull_down,
	input  wire ppw_pkg::ppw_pins_t ext_drive,
	output ppw_pkg::ppw_pins_t      pin_level
);
	import ppw_pkg::*;
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & pull_up)
		| (~pin_oe & ~pull_up & ~pull_down & ext_drive);
endmodule // ppw_pin_load

// ### verification/ppw_top_props.sv
// Concurrent property checker for the pin port top
`timescale 1ns/1ps
module ppw_top_props #(
	parameter int unsigned RST_HOLD_CYC = 20
) (
	input wire logic               core_clk,
	input wire logic               rst_n,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire ppw_pkg::ppw_pins_t configurable_pin_oe,
	input wire ppw_pkg::ppw_pins_t pin_drive_high,
	input wire ppw_pkg::ppw_pins_t pin_pull_up,
	input wire ppw_pkg::ppw_pins_t pin_pull_down,
	input wire logic               uart_rx_char,
	input wire logic               hw_reset_in_low,
	input wire logic               standby,
	input wire logic               deep_sleep,
	input wire logic               sys_reset_req,
	input wire logic               irq
);
	import ppw_pkg::*;
	logic [31:0] low_cnt;
	always_ff @(posedge core_clk) begin
		if (!rst_n || hw_reset_in_low)
			low_cnt <= 32'h0;
		else if (low_cnt != 32'hffffffff)
			low_cnt <= low_cnt + 32'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_apb_ready;
		psel && !penable |=> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
	property p_drive_oe;
		(pin_drive_high & ~configurable_pin_oe) == 19'h00000;
	endproperty
	a_drive_oe: assert property (p_drive_oe) else $error("high drive on input pin");
	property p_pull_excl;
		(pin_pull_up & pin_pull_down) == 19'h00000;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
	property p_pwr_excl;
		!(standby && deep_sleep);
	endproperty
	a_pwr_excl: assert property (p_pwr_excl) else $error("two power states at once");
	property p_rx_wake;
		standby && uart_rx_char |=> ##1 !standby && !sys_reset_req;
	endproperty
	a_rx_wake: assert property (p_rx_wake) else $error("rx did not end standby");
	property p_irq_wake;
		standby && irq |=> ##1 !standby;
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("irq did not end standby");
	property p_deep_reset;
		$fell(deep_sleep) && $past(rst_n) |-> $past(sys_reset_req);
	endproperty
	a_deep_reset: assert property (p_deep_reset) else $error("deep wake without reset");
	property p_pulse;
		sys_reset_req |=> !sys_reset_req;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset request too long");
	property p_hold;
		low_cnt == RST_HOLD_CYC - 1 |-> ##[0:3] sys_reset_req;
	endproperty
	a_hold: assert property (p_hold) else $error("long reset hold ignored");
	c_standby: cover property ($rose(standby));
	c_deep_wake: cover property ($fell(deep_sleep));
	c_irq: cover property ($rose(irq));
endmodule // ppw_top_props
////////////////////////////////////////////////////////////////////////////////
bind ppw_top ppw_top_props #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.configurable_pin_oe(configurable_pin_oe), .pin_drive_high(pin_drive_high),
	.pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .uart_rx_char(uart_rx_char),
	.hw_reset_in_low(hw_reset_in_low), .standby(standby), .deep_sleep(deep_sleep),
	.sys_reset_req(sys_reset_req), .irq(irq)
);

// ### verification/ppw_top_bench.sv
// Self-checking bench for the pin port top
`timescale 1ns/1ps
`include "ppw_params.svh"
module ppw_top_bench;
	import ppw_pkg::*;
	localparam int unsigned HOLD = 20;
	localparam logic [11:0] RV [20] = '{`PPW_OFF_DIR, `PPW_OFF_OUT, `PPW_OFF_IN, `PPW_OFF_DRIVE,
		`PPW_OFF_PULLUP, `PPW_OFF_PULLDN, `PPW_OFF_INDIS, `PPW_OFF_WAKE_EN, `PPW_OFF_WAKE_POL,
		`PPW_OFF_WAKE_CHG, `PPW_OFF_FN_PWM, `PPW_OFF_FN_SQW, `PPW_OFF_PWM_PER, `PPW_OFF_SQW_PER,
		`PPW_OFF_PWR_CTRL, `PPW_OFF_PWR_STAT, `PPW_OFF_INT_STAT, `PPW_OFF_INT_MASK,
		`PPW_OFF_PWM_DUTY, `PPW_OFF_SQW_DUTY};
	localparam int PW [6][2] = '{'{4, 0}, '{4, 1}, '{4, 3}, '{4, 6}, '{2, 1}, '{2, 2}};
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        uart_rx_char = 1'b0;
	logic        hw_reset_in_low = 1'b1;
	ppw_pins_t   ext = 19'h00000;
	ppw_pins_t   msk = 19'h00008;
	logic [31:0] prdata;
	logic        pready, pslverr, standby, deep_sleep, sys_reset_req, irq;
	ppw_pins_t   pin_in, pin_out, pin_oe, drv_hi, pu, pd, in_en;
	logic [32:0] rdq [$];
	int          errors = 0;
	int          cmp_count = 0;
	int          pulses = 0;
	int          seed = 32'he384;
	always #5 core_clk = ~core_clk;
	ppw_top #(.RST_HOLD_CYC(HOLD)) DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .configurable_pin_in(pin_in),
		.configurable_pin_out(pin_out), .configurable_pin_oe(pin_oe), .pin_drive_high(drv_hi),
		.pin_pull_up(pu), .pin_pull_down(pd), .pin_input_en(in_en), .uart_rx_char(uart_rx_char),
		.hw_reset_in_low(hw_reset_in_low), .standby(standby), .deep_sleep(deep_sleep),
		.sys_reset_req(sys_reset_req), .irq(irq));
	ppw_pin_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pu), .pull_down(pd),
		.ext_drive(ext), .pin_level(pin_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tally(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		tally(got === exp, got, exp);
	endtask
	task automatic chk_pins(input ppw_pins_t got, input ppw_pins_t exp);
		tally(got === exp, {13'h0, got}, {13'h0, exp});
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		tally(got === exp, {31'h0, got}, {31'h0, exp});
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
		rdq.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask
	function automatic ppw_pins_t rnd19();
		int r;
		r = $random(seed);
		return r[18:0];
	endfunction
	task automatic step(input ppw_pins_t ev, input ppw_pins_t e1, input ppw_pins_t e2);
		ext <= ev;
		repeat (3) @(posedge core_clk);
		rd(`PPW_OFF_INT_STAT, {13'h0, e1});
		wr(`PPW_OFF_INT_STAT, 32'hfffff);
		repeat (3) @(posedge core_clk);
		rd(`PPW_OFF_INT_STAT, {13'h0, e2});
		chk_bit(irq, |(e2 & msk));
	endtask
	task automatic hi_count(input int b, input int len, output int hc);
		hc = 0;
		repeat (len) begin
			@(posedge core_clk);
			if (pin_out[b] === 1'b1)
				hc++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Read data monitor and reset pulse counter
	always @(posedge core_clk) begin
		logic [32:0] e;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = rdq.pop_front();
			chk_val(prdata, e[31:0]);
			chk_bit(pslverr, e[32]);
		end
		if (sys_reset_req === 1'b1)
			pulses++;
	end
	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		close_out();
	end
	initial begin
		ppw_pins_t dir, out, drv, up, dn, dis, upr, dnr;
		int hc;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (RV[i])
			rd(RV[i], 32'h0);
		rd(12'h0fc, 32'h0, 1'b1);
		chk_pins(in_en, 19'h7ffff);
		$display("done: reset values");
		repeat (3) begin
			dir = rnd19();
			out = rnd19();
			drv = rnd19();
			up = rnd19();
			dn = rnd19();
			dis = rnd19();
			ext <= rnd19();
			wr(`PPW_OFF_DIR, {13'h0, dir});
			wr(`PPW_OFF_OUT, {13'h0, out});
			wr(`PPW_OFF_DRIVE, {13'h0, drv});
			wr(`PPW_OFF_PULLUP, {13'h0, up});
			wr(`PPW_OFF_PULLDN, {13'h0, dn});
			wr(`PPW_OFF_INDIS, {13'h0, dis});
			repeat (3) @(posedge core_clk);
			upr = up & ~dn;
			dnr = dn & ~up;
			chk_pins(pin_oe, dir);
			chk_pins(pin_out & dir, out & dir);
			chk_pins(drv_hi, drv & dir);
			chk_pins(pu, upr);
			chk_pins(pd, dnr);
			chk_pins(in_en, ~dis);
			rd(`PPW_OFF_IN, {13'h0, ((dir & out) | (~dir & upr) | (~dir & ~upr & ~dnr & ext)) & ~dis});
		end
		$display("done: pin configuration");
		ext <= 19'h00020;
		wr(`PPW_OFF_DIR, 32'h0);
		wr(`PPW_OFF_PULLUP, 32'h0);
		wr(`PPW_OFF_PULLDN, 32'h0);
		wr(`PPW_OFF_INDIS, 32'h0);
		wr(`PPW_OFF_WAKE_POL, 32'h00008);
		wr(`PPW_OFF_WAKE_CHG, 32'h00080);
		wr(`PPW_OFF_WAKE_EN, 32'h000a8);
		wr(`PPW_OFF_INT_MASK, 32'h00008);
		step(19'h00020, 19'h0, 19'h0);
		step(19'h00028, 19'h8, 19'h8);
		step(19'h00008, 19'h28, 19'h28);
		step(19'h000a0, 19'ha8, 19'h0);
		step(19'h00020, 19'h80, 19'h0);
		msk = 19'h0;
		wr(`PPW_OFF_INT_MASK, 32'h0);
		step(19'h00028, 19'h8, 19'h8);
		msk = 19'h8;
		wr(`PPW_OFF_INT_MASK, 32'h8);
		step(19'h00020, 19'h8, 19'h0);
		$display("done: wake and interrupt");
		wr(`PPW_OFF_WAKE_EN, 32'h0);
		wr(`PPW_OFF_INT_MASK, 32'h80000);
		wr(`PPW_OFF_PWR_CTRL, 32'h1);
		repeat (2) @(posedge core_clk);
		chk_bit(standby, 1'b1);
		rd(`PPW_OFF_PWR_STAT, 32'h1);
		uart_rx_char <= 1'b1;
		@(posedge core_clk);
		uart_rx_char <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk_bit(standby, 1'b0);
		rd(`PPW_OFF_INT_STAT, 32'h80000);
		wr(`PPW_OFF_PWR_CTRL, 32'h1);
		repeat (2) @(posedge core_clk);
		chk_bit(standby, 1'b0);
		chk_val(pulses, 32'h0);
		wr(`PPW_OFF_INT_STAT, 32'hfffff);
		$display("done: standby");
		wr(`PPW_OFF_WAKE_EN, 32'h8);
		wr(`PPW_OFF_PWR_CTRL, 32'h2);
		repeat (2) @(posedge core_clk);
		chk_bit(deep_sleep, 1'b1);
		rd(`PPW_OFF_PWR_STAT, 32'h2);
		ext <= 19'h00028;
		repeat (4) @(posedge core_clk);
		chk_bit(deep_sleep, 1'b0);
		chk_val(pulses, 32'h1);
		ext <= 19'h00020;
		wr(`PPW_OFF_WAKE_EN, 32'h0);
		$display("done: deep sleep");
		hw_reset_in_low <= 1'b0;
		repeat (HOLD - 3) @(posedge core_clk);
		hw_reset_in_low <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk_val(pulses, 32'h1);
		hw_reset_in_low <= 1'b0;
		repeat (HOLD + 10) @(posedge core_clk);
		hw_reset_in_low <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk_val(pulses, 32'h2);
		$display("done: reset input");
		wr(`PPW_OFF_FN_PWM, 32'h40000);
		foreach (PW[i]) begin
			wr(`PPW_OFF_PWM_PER, 32'(PW[i][0]));
			wr(`PPW_OFF_PWM_DUTY + 12'h048, 32'(PW[i][1]));
			repeat (800) @(posedge core_clk);
			hi_count(18, PW[i][0] * 100, hc);
			chk_val(hc, 32'((PW[i][1] > PW[i][0] ? PW[i][0] : PW[i][1]) * 100));
		end
		chk_bit(pin_oe[18], 1'b1);
		$display("done: pwm");
		wr(`PPW_OFF_FN_PWM, 32'h0);
		wr(`PPW_OFF_FN_SQW, 32'h8001);
		wr(`PPW_OFF_SQW_PER, 32'd40);
		wr(`PPW_OFF_SQW_DUTY + 12'h03c, 32'd10);
		repeat (200) @(posedge core_clk);
		hi_count(0, 40, hc);
		chk_val(hc, 32'd20);
		hi_count(15, 40, hc);
		chk_val(hc, 32'd10);
		chk_pins(pin_oe & 19'h08001, 19'h08001);
		$display("done: square wave");
		close_out();
	end
endmodule // ppw_top_bench
